// ===== include/ccpc_defs.svh
/*
 * constants of the card clock power control block: register offsets,
 * field positions, reset values and timing counts.
 * assumes: included by its bare name by the package and design files.
 */
`ifndef CCPC_DEFS_SVH
`define CCPC_DEFS_SVH

// register offsets (byte addresses)
`define CCPC_ADDR_W            8
`define CCPC_OFS_SKT_CTRL      8'h10
`define CCPC_OFS_PWR_CTRL      8'h20
`define CCPC_OFS_IRQ_STAT      8'h24
`define CCPC_OFS_IRQ_MASK      8'h28

// socket_clock_power_ctrl fields
`define CCPC_BIT_ACCESS        25
`define CCPC_BIT_MODE          24
`define CCPC_BIT_SEL_EN        16
`define CCPC_BIT_STOP_SLOW     0
// socket control field kept here
`define CCPC_BIT_IDLE_POLICY   7
// interrupt status and mask fields
`define CCPC_IRQ_W             2
`define CCPC_IRQ_ACCESS        0
`define CCPC_IRQ_MODE          1

// reset values
`define CCPC_PWR_RESET         32'h0000_0000
`define CCPC_ZERO32            32'h0000_0000
`define CCPC_IRQ_RESET         2'h0

// timing
`define CCPC_CLK_PERIOD_NS     4
`define CCPC_IDLE_NS           1000
`define CCPC_IDLE_CYCLES       ((`CCPC_IDLE_NS + `CCPC_CLK_PERIOD_NS - 1) / `CCPC_CLK_PERIOD_NS)
`define CCPC_IDLE_CNT_W        9
`define CCPC_SLOW_DIV          16
`define CCPC_DIV_CNT_W         4

`endif

// ===== include/ccpc_pkg.sv
/*
 * types of the card clock power control block.
 * assumes: ccpc_defs.svh sits in the include path.
 */
`include "ccpc_defs.svh"

package ccpc_pkg;

	// card clock drive modes
	typedef enum logic [1:0] {
		CCPC_CLK_RUN  = 2'h0,
		CCPC_CLK_SLOW = 2'h1,
		CCPC_CLK_STOP = 2'h2
	} ccpc_clk_mode_t;

	// idle state machine, gray along run -> wait -> reduced
	typedef enum logic [1:0] {
		CCPC_ST_RUN     = 2'h0,
		CCPC_ST_WAIT    = 2'h1,
		CCPC_ST_REDUCED = 2'h3
	} ccpc_state_t;

endpackage : ccpc_pkg

// ===== design/ccpc_sync.sv
/*
 * two flip-flop synchroniser for one level from outside the clk domain.
 * assumes: the input is a level or a slow clock, held for several clk cycles.
 */
`timescale 1ns/1ns

module ccpc_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// level in and out
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : ccpc_sync

// ===== design/ccpc_clkdiv.sv
/*
 * card clock generator: follows the sampled source clock, divides it by
 * sixteen, or parks it low.
 * assumes: src_edge pulses once for every edge of the sampled source clock.
 */
`timescale 1ns/1ns

`include "ccpc_defs.svh"

module ccpc_clkdiv (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// source edges and mode
	input  wire logic                   src_edge,
	input  wire ccpc_pkg::ccpc_clk_mode_t mode,
	// card clock
	output logic                        card_clk_r
);
	import ccpc_pkg::*;

	logic [`CCPC_DIV_CNT_W-1:0] div_cnt_r;

	// divide count: one card clock half period per sixteen source edges
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt_r <= '0;
		end else if (src_edge) begin
			if (mode == CCPC_CLK_SLOW) begin
				div_cnt_r <= div_cnt_r + `CCPC_DIV_CNT_W'(1);
			end else begin
				div_cnt_r <= '0;
			end
		end
	end

	// toggles only on source edges, so no runt pulse when modes change
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			card_clk_r <= 1'b0;
		end else if (src_edge) begin
			case (mode)
				CCPC_CLK_RUN: begin
					card_clk_r <= ~card_clk_r;
				end
				CCPC_CLK_SLOW: begin
					if (div_cnt_r == `CCPC_DIV_CNT_W'(`CCPC_SLOW_DIV - 1)) begin
						card_clk_r <= ~card_clk_r; // RULE6
					end
				end
				default: begin
					card_clk_r <= 1'b0; // RULE5
				end
			endcase
		end
	end

endmodule : ccpc_clkdiv

// ===== design/ccpc_top.sv
/*
 * card clock power control: the socket clock power control register, the
 * idle policy bit, interrupt status and mask, the idle state machine and
 * the card clock generator.
 * assumes: card_access pulses on clk for each card access; host_clk_stop_req
 * is a level on clk; card_busy_pin and cb_clk_src come from outside.
 */
// Chosen here: the plain strobed port.
//
// Behaviour
// RULE1: every access to the card sets the socket access flag, which reads 0 otherwise.
// RULE2: reading the power control register clears the socket access flag.
// RULE3: the clock mode flag reads 1 while the card clock is stopped or slowed, else 0.
// RULE4: stop or slow select acts only while the enable bit is 1; the enable resets to 0.
// RULE5: with stop or slow select at 0 an idle card clock is halted.
// RULE6: with stop or slow select at 1 an idle card clock runs at a sixteenth of its rate.
// RULE7: the clock is reduced only while the socket is idle.
// RULE8: all reserved bits of the register read as zero.
// RULE9: after reset the socket access flag reads 0.
// RULE10: the policy bit picks reducing on socket idle alone or only with host clock stop.
// RULE11: with the enable bit at 0 an idle clock is halted, not slowed.
`timescale 1ns/1ns

`include "ccpc_defs.svh"

module ccpc_top (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	// register port
	input  wire logic [`CCPC_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [31:0]             reg_rdata_r,
	// host side events
	input  wire logic                    card_access,
	input  wire logic                    host_clk_stop_req,
	// socket pins
	input  wire logic                    card_busy_pin,
	input  wire logic                    cb_clk_src,
	output logic                         card_clk,
	// interrupt
	output logic                         irq_r
);
	import ccpc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic                        socket_access_flag_r;
	logic                        clock_mode_flag_r;
	logic                        clock_select_enable_r;
	logic                        stop_or_slow_select_r;
	logic                        idle_gate_policy_r;
	logic [`CCPC_IRQ_W-1:0]      irq_stat_r;
	logic [`CCPC_IRQ_W-1:0]      irq_mask_r;
	logic [`CCPC_IRQ_W-1:0]      irq_event;
	logic [`CCPC_IDLE_CNT_W-1:0] idle_cnt_r;
	ccpc_state_t                 state_r;
	ccpc_state_t                 state_nxt;
	ccpc_clk_mode_t              clk_mode;
	logic                        busy_s;
	logic                        src_s;
	logic                        src_d_r;
	logic                        src_edge;
	logic                        socket_idle;
	logic                        reduce_ok;
	logic                        idle_done;
	logic                        slow_sel;
	logic                        wr_pwr;
	logic                        wr_skt;
	logic                        wr_stat;
	logic                        wr_mask;
	logic                        rd_pwr;
	logic [31:0]                 pwr_view;
	logic                        mode_nxt;

	////////////////////////////////////////////////////////////////////////
	// pin sampling

	ccpc_sync #(
		.RESET_VAL (1'b0)
	) u_busy_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (card_busy_pin),
		.sync_out (busy_s)
	);

	ccpc_sync #(
		.RESET_VAL (1'b0)
	) u_src_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (cb_clk_src),
		.sync_out (src_s)
	);

	// edge finder reads the second stage only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			src_d_r <= 1'b0;
		end else begin
			src_d_r <= src_s;
		end
	end

	assign src_edge = src_s ^ src_d_r;

	////////////////////////////////////////////////////////////////////////
	// register decode

	always_comb begin
		wr_pwr  = 1'b0;
		wr_skt  = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		rd_pwr  = 1'b0;
		if (reg_addr == `CCPC_OFS_PWR_CTRL) begin
			wr_pwr = reg_wr;
			rd_pwr = reg_rd;
		end else if (reg_addr == `CCPC_OFS_SKT_CTRL) begin
			wr_skt = reg_wr;
		end else if (reg_addr == `CCPC_OFS_IRQ_STAT) begin
			wr_stat = reg_wr;
		end else if (reg_addr == `CCPC_OFS_IRQ_MASK) begin
			wr_mask = reg_wr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control bits

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clock_select_enable_r <= 1'b0; // RULE4
			stop_or_slow_select_r <= 1'b0; // RULE5
		end else if (wr_pwr) begin
			clock_select_enable_r <= reg_wdata[`CCPC_BIT_SEL_EN];
			stop_or_slow_select_r <= reg_wdata[`CCPC_BIT_STOP_SLOW];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			idle_gate_policy_r <= 1'b0;
		end else if (wr_skt) begin
			idle_gate_policy_r <= reg_wdata[`CCPC_BIT_IDLE_POLICY];
		end
	end

	// the select bit is ignored, not cleared, while disabled
	assign slow_sel = clock_select_enable_r & stop_or_slow_select_r; // RULE4 RULE11

	////////////////////////////////////////////////////////////////////////
	// socket access flag

	// a new access in the read cycle survives, so none is missed
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			socket_access_flag_r <= 1'b0; // RULE9
		end else if (card_access) begin
			socket_access_flag_r <= 1'b1; // RULE1
		end else if (rd_pwr) begin
			socket_access_flag_r <= 1'b0; // RULE2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// idle detection

	assign socket_idle = ~busy_s & ~card_access;
	// policy 0 waits for the host clock to go down as well
	assign reduce_ok   = idle_gate_policy_r | host_clk_stop_req; // RULE10
	assign idle_done   = (idle_cnt_r == `CCPC_IDLE_CNT_W'(`CCPC_IDLE_CYCLES - 1));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			idle_cnt_r <= '0;
		end else if (state_r != CCPC_ST_WAIT || !socket_idle) begin
			idle_cnt_r <= '0;
		end else if (!idle_done) begin
			idle_cnt_r <= idle_cnt_r + `CCPC_IDLE_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// idle state machine

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CCPC_ST_RUN: begin
				if (socket_idle && reduce_ok) begin
					state_nxt = CCPC_ST_WAIT;
				end
			end
			CCPC_ST_WAIT: begin
				if (!socket_idle || !reduce_ok) begin
					state_nxt = CCPC_ST_RUN;
				end else if (idle_done) begin
					state_nxt = CCPC_ST_REDUCED; // RULE7
				end
			end
			CCPC_ST_REDUCED: begin
				// any activity brings the full clock back at once
				if (!socket_idle || !reduce_ok) begin
					state_nxt = CCPC_ST_RUN; // RULE7
				end
			end
			default: begin
				state_nxt = CCPC_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= CCPC_ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		if (state_r != CCPC_ST_REDUCED) begin
			clk_mode = CCPC_CLK_RUN;
		end else if (slow_sel) begin
			clk_mode = CCPC_CLK_SLOW; // RULE6
		end else begin
			clk_mode = CCPC_CLK_STOP; // RULE5 RULE11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// card clock

	ccpc_clkdiv u_clkdiv (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.src_edge   (src_edge),
		.mode       (clk_mode),
		.card_clk_r (card_clk)
	);

	assign mode_nxt = (state_nxt == CCPC_ST_REDUCED);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clock_mode_flag_r <= 1'b0;
		end else begin
			clock_mode_flag_r <= mode_nxt; // RULE3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts

	assign irq_event[`CCPC_IRQ_ACCESS] = card_access;
	assign irq_event[`CCPC_IRQ_MODE]   = mode_nxt ^ clock_mode_flag_r;

	// write one to clear; a same-cycle event wins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_r <= `CCPC_IRQ_RESET;
		end else if (wr_stat) begin
			irq_stat_r <= (irq_stat_r & ~reg_wdata[`CCPC_IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat_r <= irq_stat_r | irq_event;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_mask_r <= `CCPC_IRQ_RESET;
		end else if (wr_mask) begin
			irq_mask_r <= reg_wdata[`CCPC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data

	always_comb begin
		pwr_view                       = `CCPC_ZERO32; // RULE8
		pwr_view[`CCPC_BIT_ACCESS]     = socket_access_flag_r;
		pwr_view[`CCPC_BIT_MODE]       = clock_mode_flag_r;
		pwr_view[`CCPC_BIT_SEL_EN]     = clock_select_enable_r;
		pwr_view[`CCPC_BIT_STOP_SLOW]  = stop_or_slow_select_r;
	end

	// data stand for exactly the cycle after the read strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_r <= `CCPC_ZERO32;
		end else if (!reg_rd) begin
			reg_rdata_r <= `CCPC_ZERO32;
		end else if (reg_addr == `CCPC_OFS_PWR_CTRL) begin
			reg_rdata_r <= pwr_view; // RULE8
		end else if (reg_addr == `CCPC_OFS_SKT_CTRL) begin
			reg_rdata_r <= {24'h00_0000, idle_gate_policy_r, 7'h00};
		end else if (reg_addr == `CCPC_OFS_IRQ_STAT) begin
			reg_rdata_r <= {30'h0000_0000, irq_stat_r};
		end else if (reg_addr == `CCPC_OFS_IRQ_MASK) begin
			reg_rdata_r <= {30'h0000_0000, irq_mask_r};
		end else begin
			reg_rdata_r <= `CCPC_ZERO32;
		end
	end

endmodule : ccpc_top

// ===== testbench/ccpc_assertions.sv
/* port checks of the card clock power control block.
   assumes: bound to ccpc_top; one clock domain. */
`timescale 1ns/1ns
`include "ccpc_defs.svh"
module ccpc_assertions (
	// clock and reset
	input wire logic                    clk,
	input wire logic                    sys_rst,
	// register port
	input wire logic [`CCPC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0]             reg_wdata,
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [31:0]             reg_rdata_r,
	// events, pins, outputs
	input wire logic                    card_access,
	input wire logic                    card_busy_pin,
	input wire logic                    card_clk,
	input wire logic                    irq_r
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence rd_pwr;
		reg_rd && reg_addr == 8'h20 && !card_access;
	endsequence
	//////////////////////////////////////////////////////////////////////
	chk_rsvd_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h20 |->
		(reg_rdata_r & 32'hfcfe_fffe) == 32'h0000_0000) else $error("reserved bits set");
	chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h30 |->
		reg_rdata_r == 32'h0000_0000) else $error("unmapped read not zero");
	chk_access_sets: assert property (card_access ##1 rd_pwr |=> reg_rdata_r[25])
		else $error("access flag not set");
	chk_read_clears: assert property (rd_pwr ##1 !card_access ##1 rd_pwr |=>
		!reg_rdata_r[25]) else $error("access flag not cleared");
	chk_rw_bits: assert property (reg_wr && reg_addr == 8'h20 ##1 rd_pwr |=>
		(reg_rdata_r & 32'h0001_0001) == ($past(reg_wdata, 2) & 32'h0001_0001))
		else $error("control bits lost");
	chk_mode_busy: assert property (card_busy_pin [*6] ##0 rd_pwr |=> !reg_rdata_r[24])
		else $error("mode flag set while busy");
	// clock must run while the socket works
	chk_clk_busy: assert property (card_busy_pin [*6] |->
		##[0:40] card_clk != $past(card_clk)) else $error("card clock held while busy");
	chk_irq_masked: assert property (reg_wr && reg_addr == 8'h28 &&
		reg_wdata == 32'h0000_0000 |=> ##1 !irq_r) else $error("masked interrupt seen");
endmodule : ccpc_assertions

// ===== testbench/ccpc_card_model.sv
/* card on the socket: free running source clock and the activity pin.
   assumes: busy_cmd comes from the bench. */
`timescale 1ns/1ns
module ccpc_card_model (
	// command from bench
	input wire logic busy_cmd,
	// socket pins
	output logic     card_busy_pin,
	output logic     cb_clk_src
);
	// pin moves off the clk edge, as an unrelated card would
	initial card_busy_pin = 1'b0;
	always @(busy_cmd) card_busy_pin <= #7 busy_cmd;
	// 125 ns period, split 62/63 on a 1 ns grid
	initial begin
		cb_clk_src = 1'b0;
		forever begin
			#62 cb_clk_src = 1'b1;
			#63 cb_clk_src = 1'b0;
		end
	end
endmodule : ccpc_card_model

// ===== testbench/ccpc_tb_top.sv
/* bench of the card clock power control: register rows, then reset,
   access, interrupt and idle clock cases.
   assumes: design, checker and card model compiled before. */
`timescale 1ns/1ns
`include "ccpc_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module ccpc_tb_top;
	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} ccpc_row_t;
	logic        clk, sys_rst, reg_wr, reg_rd, card_access, host_clk_stop_req, busy_cmd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata_r, d;
	logic        card_busy_pin, cb_clk_src, card_clk, irq_r;
	int          mismatches, checked, cycles, n;
	logic [7:0]  ra [4] = '{8'h20, 8'h10, 8'h24, 8'h28};
	ccpc_row_t   rows [7] = '{
		'{8'h20, 32'hffff_ffff, 32'h0001_0001}, '{8'h20, 32'h0000_0000, 32'h0000_0000},
		'{8'h10, 32'hffff_ffff, 32'h0000_0080}, '{8'h10, 32'h0000_0000, 32'h0000_0000},
		'{8'h28, 32'hffff_ffff, 32'h0000_0003}, '{8'h28, 32'h0000_0000, 32'h0000_0000},
		'{8'h30, 32'hffff_ffff, 32'h0000_0000}};
	ccpc_top u_ccpc_top (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_r, .card_access, .host_clk_stop_req, .card_busy_pin, .cb_clk_src,
		.card_clk, .irq_r);
	ccpc_card_model u_ccpc_card_model (.busy_cmd, .card_busy_pin, .cb_clk_src);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata_r;
		@(posedge clk);
	endtask : rd
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
	endtask : idle
	task automatic busy_pulse;
		busy_cmd <= 1'b1;
		idle(20);
		busy_cmd <= 1'b0;
	endtask : busy_pulse
	// cycles between two card clock edges, 700 when it stands still
	task automatic gap(output int g);
		logic s;
		g = 0;
		for (int k = 0; k < 2 && g < 700; k++) begin
			g = 0;
			s = card_clk;
			while (card_clk === s && g < 700) begin
				@(posedge clk);
				g++;
			end
		end
	endtask : gap
	task automatic complete_run;
		$display("counts: checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	// ceiling well above the ~3600 cycles the cases need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 12000) begin
			mismatches++;
			complete_run();
		end
	end
	//////////////////////////////////////////////////////////////////////
	initial begin
		{sys_rst, reg_wr, reg_rd, card_access, host_clk_stop_req, busy_cmd} = 6'b10_0000;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		idle(20);
		sys_rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, d);
			`CHK(d, rows[i].e)
		end
		$display("done: register rows");
		wr(8'h20, 32'h0001_0001);
		wr(8'h10, 32'h0000_0080);
		sys_rst <= 1'b1;
		idle(2);
		sys_rst <= 1'b0;
		@(posedge clk);
		foreach (ra[i]) begin
			rd(ra[i], d);
			`CHK(d, 32'h0000_0000)
		end
		$display("done: reset in mid run");
		wr(8'h28, 32'h0000_0001);
		card_access <= 1'b1;
		@(posedge clk);
		card_access <= 1'b0;
		rd(8'h20, d);
		`CHK(d, 32'h0200_0000)
		`CHK(irq_r, 1'b1)
		rd(8'h20, d);
		`CHK(d, 32'h0000_0000)
		rd(8'h24, d);
		`CHK(d, 32'h0000_0001)
		wr(8'h24, 32'h0000_0001);
		idle(2);
		`CHK(irq_r, 1'b0)
		wr(8'h28, 32'h0000_0000);
		card_access <= 1'b1;
		@(posedge clk);
		card_access <= 1'b0;
		idle(3);
		`CHK(irq_r, 1'b0)
		rd(8'h24, d);
		`CHK(d, 32'h0000_0001)
		wr(8'h24, 32'h0000_0003);
		$display("done: access and interrupt");
		wr(8'h10, 32'h0000_0080);
		idle(300);
		// access flag still holds the masked access above: no read of 0x20 since
		rd(8'h20, d);
		`CHK(d, 32'h0300_0000)
		rd(8'h24, d);
		`CHK(d, 32'h0000_0002)
		gap(n);
		`CHK(n == 700 && card_clk === 1'b0, 1'b1)
		$display("done: idle stop");
		wr(8'h20, 32'h0001_0001);
		busy_cmd <= 1'b1;
		idle(20);
		rd(8'h20, d);
		`CHK(d, 32'h0001_0001)
		gap(n);
		`CHK(n >= 14 && n <= 17, 1'b1)
		busy_cmd <= 1'b0;
		idle(300);
		rd(8'h20, d);
		`CHK(d, 32'h0101_0001)
		gap(n);
		`CHK(n >= 248 && n <= 252, 1'b1)
		$display("done: idle slow");
		wr(8'h20, 32'h0000_0001);
		busy_pulse();
		idle(300);
		gap(n);
		`CHK(n == 700 && card_clk === 1'b0, 1'b1)
		$display("done: select without enable");
		wr(8'h10, 32'h0000_0000);
		busy_pulse();
		idle(300);
		rd(8'h20, d);
		`CHK(d, 32'h0000_0001)
		host_clk_stop_req <= 1'b1;
		idle(300);
		rd(8'h20, d);
		`CHK(d, 32'h0100_0001)
		host_clk_stop_req <= 1'b0;
		$display("done: idle gate policy");
		complete_run();
	end
endmodule : ccpc_tb_top

bind ccpc_top ccpc_assertions u_ccpc_assertions (.clk, .sys_rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata_r, .card_access, .card_busy_pin, .card_clk, .irq_r);
